// ==== pdseq_pkg.sv ====
// Package: shared types and constants for the power-profile pin sequencer
package pdseq_pkg;

   // Clock period and pin sequencing gap
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned PIN_GAP_NS = 12500;
   // Longest gap rounds down to whole cycles
   localparam int unsigned PIN_GAP_CYC = PIN_GAP_NS / CLK_PERIOD_NS;
   localparam int unsigned GAP_W = 11;

   // Reset values of the pins
   localparam logic RST_PIN = 1'b0;

   typedef enum logic [1:0] {PDSEQ_V5, PDSEQ_V9, PDSEQ_V20} pdseq_level_e;

   typedef enum {
      PDSEQ_SNK_IDLE, PDSEQ_SNK_SINK_CURRENT_SELECT, PDSEQ_SNK_ON,
      PDSEQ_SRC_UNATT, PDSEQ_SRC_ON, PDSEQ_SRC_BREAK
   } pdseq_state_e;

   // Sink indication and switch pins
   typedef struct packed {
      logic [1:0] sink_current_select;
      logic load_switch_enable;
   } pdseq_sink_pins_s;

   // Source supply pins
   typedef struct packed {
      logic source_supply_switch;
      logic rail_9v_select;
      logic rail_20v_select;
      logic vbus_on;
      logic vconn_on;
   } pdseq_src_pins_s;

endpackage : pdseq_pkg

// ==== pdseq_supply_model.sv ====
// Behavioural model of the external load switch and DC/DC supply
`timescale 1ns/1ns
`default_nettype none
module pdseq_supply_model
   import pdseq_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire pdseq_src_pins_s src_i,
   input wire pdseq_sink_pins_s sink_i,
   output logic [4:0] volts_o,
   output logic load_on_o,
   output logic clash_o
);
   ////////////////////////////////////////////////////////////////////////
   // Rail pins pick the output; a gap with no rail pin falls back to 5 V
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         volts_o <= 5'h00;
         load_on_o <= 1'b0;
      end else begin
         if (!src_i.source_supply_switch) begin
            volts_o <= 5'h00;
         end else if (src_i.rail_20v_select) begin
            volts_o <= 5'h14;
         end else if (src_i.rail_9v_select) begin
            volts_o <= 5'h09;
         end else begin
            volts_o <= 5'h05;
         end
         load_on_o <= sink_i.load_switch_enable;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Both rails at once would short two regulators; latched for the bench
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         clash_o <= 1'b0;
      end else begin
         clash_o <= clash_o | (src_i.rail_9v_select & src_i.rail_20v_select);
      end
   end
endmodule : pdseq_supply_model
`default_nettype wire

// ==== pdseq_sync.sv ====
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module pdseq_sync (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic d_i,
   output logic q_o
);
   logic s1;
   logic s2;
   logic s3;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= d_i;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // Change accepted only once the later two stages agree
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q_o <= 1'b0;
      end else if (s2 == s3) begin
         q_o <= s3;
      end
   end
endmodule : pdseq_sync
`default_nettype wire

// ==== pdseq_top.sv ====
// Power-profile pin sequencer for a Type-C PD port
// Function
// [R1] The port starts as sink after reset and goes to source only on a swap.
// [R2] In sink role dedicated pins carry current select and load switch enable.
// [R3] The sequenced pins have no general-purpose software path at all.
// [R4] After a sink profile is agreed, current select rises before load enable.
// [R5] The current select to load enable gap is at most 12.5 us.
// [R6] As source the supply starts at 5 V and may then move to a higher level.
// [R7] Supply switch stays high at every level; each rail pin only at its level.
// [R8] Going up from 5 V only raises one rail pin, with no ordering.
// [R9] From 9 V to 20 V the 9 V pin drops, then the 20 V pin rises within 12.5 us.
// [R10] A source sees the sink pull-down, attaches, then turns on VBUS and VCONN.
// [R11] An external controller may take over the policy commands.
// [R12] Returning to 5 V drops the active rail pin and keeps the supply switch.
`timescale 1ns/1ns
`default_nettype none
module pdseq_top
   import pdseq_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   // Policy commands from the internal processor
   input wire logic int_sink_ok_i,
   input wire logic [1:0] int_sink_prof_i,
   input wire logic int_swap_i,
   input wire pdseq_level_e int_level_i,
   // Policy commands from an external controller
   input wire logic ext_take_i,
   input wire logic ext_sink_ok_i,
   input wire logic [1:0] ext_sink_prof_i,
   input wire logic ext_swap_i,
   input wire pdseq_level_e ext_level_i,
   // Sink pull-down seen on the configuration channel (comparator pin)
   input wire logic cc_sink_seen_i,
   output pdseq_sink_pins_s sink_pins_o,
   output pdseq_src_pins_s src_pins_o,
   output logic source_role_o
);

   ////////////////////////////////////////////////////////////////////////
   pdseq_state_e state;
   logic [GAP_W-1:0] gap;
   logic cc_seen;
   logic sink_ok;
   logic [1:0] sink_prof;
   logic swap;
   pdseq_level_e level;
   pdseq_level_e cur;
   logic gap_done;

   pdseq_sync u_cc_sync (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .d_i(cc_sink_seen_i),
      .q_o(cc_seen)
   );

   // Policy source select; no software write reaches the pins
   always_comb begin
      sink_ok = ext_take_i ? ext_sink_ok_i : int_sink_ok_i; // R11 R3
      sink_prof = ext_take_i ? ext_sink_prof_i : int_sink_prof_i; // R11
      swap = ext_take_i ? ext_swap_i : int_swap_i; // R11
      level = ext_take_i ? ext_level_i : int_level_i; // R11
   end

   // Gap timer is a fixed 1250-cycle delay, equal to the 12.5 us bound
   assign gap_done = (gap == GAP_W'(PIN_GAP_CYC - 1)); // R5 R9

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state <= PDSEQ_SNK_IDLE; // R1
      end else begin
         case (state)
            PDSEQ_SNK_IDLE: begin
               if (swap) begin
                  state <= PDSEQ_SRC_UNATT; // R1
               end else if (sink_ok) begin
                  state <= PDSEQ_SNK_SINK_CURRENT_SELECT; // R4
               end
            end
            PDSEQ_SNK_SINK_CURRENT_SELECT: begin
               if (!sink_ok) begin
                  state <= PDSEQ_SNK_IDLE;
               end else if (gap_done) begin
                  state <= PDSEQ_SNK_ON; // R4
               end
            end
            PDSEQ_SNK_ON: begin
               if (!sink_ok) begin
                  state <= PDSEQ_SNK_IDLE;
               end
            end
            PDSEQ_SRC_UNATT: begin
               if (cc_seen) begin
                  state <= PDSEQ_SRC_ON; // R10
               end
            end
            PDSEQ_SRC_ON: begin
               if (!cc_seen) begin
                  state <= PDSEQ_SRC_UNATT;
               end else if (cur == PDSEQ_V9 && level == PDSEQ_V20) begin
                  state <= PDSEQ_SRC_BREAK; // R9
               end
            end
            PDSEQ_SRC_BREAK: begin
               if (!cc_seen) begin
                  state <= PDSEQ_SRC_UNATT;
               end else if (gap_done) begin
                  state <= PDSEQ_SRC_ON; // R9
               end
            end
            default: begin
               state <= PDSEQ_SNK_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         gap <= '0;
      end else if (state == PDSEQ_SNK_SINK_CURRENT_SELECT || state == PDSEQ_SRC_BREAK) begin
         gap <= gap + GAP_W'(1);
      end else begin
         gap <= '0;
      end
   end

   // Level actually on the rails; every attach starts at 5 V
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cur <= PDSEQ_V5;
      end else if (state != PDSEQ_SRC_ON) begin
         if (state == PDSEQ_SRC_BREAK && gap_done) begin
            cur <= PDSEQ_V20; // R9
         end else if (state != PDSEQ_SRC_BREAK) begin
            cur <= PDSEQ_V5; // R6
         end
      end else if (cc_seen && !(cur == PDSEQ_V9 && level == PDSEQ_V20)) begin
         cur <= level; // R8 R12
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sink_pins_o <= '0;
      end else begin
         sink_pins_o.sink_current_select <=
            (state == PDSEQ_SNK_SINK_CURRENT_SELECT || state == PDSEQ_SNK_ON) && sink_ok
            ? sink_prof : 2'h0; // R2 R4
         sink_pins_o.load_switch_enable <=
            (state == PDSEQ_SNK_ON && sink_ok) ||
            (state == PDSEQ_SNK_SINK_CURRENT_SELECT && sink_ok && gap_done); // R2 R4
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         src_pins_o <= '0;
         source_role_o <= RST_PIN; // R1
      end else begin
         source_role_o <= (state == PDSEQ_SRC_UNATT) ||
            (state == PDSEQ_SRC_ON) || (state == PDSEQ_SRC_BREAK);
         src_pins_o.source_supply_switch <= (state == PDSEQ_SRC_ON) ||
            (state == PDSEQ_SRC_BREAK); // R7 R12
         src_pins_o.vbus_on <= (state == PDSEQ_SRC_ON) ||
            (state == PDSEQ_SRC_BREAK); // R10
         src_pins_o.vconn_on <= (state == PDSEQ_SRC_ON) ||
            (state == PDSEQ_SRC_BREAK); // R10
         src_pins_o.rail_9v_select <= (state == PDSEQ_SRC_ON) &&
            (cur == PDSEQ_V9); // R7
         src_pins_o.rail_20v_select <= (state == PDSEQ_SRC_ON) &&
            (cur == PDSEQ_V20); // R7
      end
   end

   ////////////////////////////////////////////////////////////////////////
   sequence s_sink_current_select_up;
      $rose(|sink_pins_o.sink_current_select);
   endsequence

   // Long pin gaps are counted here; a delay range over the whole window
   // would be far too costly for the tools to unroll
   logic [GAP_W-1:0] sink_current_select_wait;
   logic [GAP_W-1:0] brk_wait;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sink_current_select_wait <= '0;
      end else if (|sink_pins_o.sink_current_select &&
         !sink_pins_o.load_switch_enable) begin
         sink_current_select_wait <= sink_current_select_wait + GAP_W'(1); // R5
      end else begin
         sink_current_select_wait <= '0;
      end
   end

   // Counts from the 9 V pin drop until the 20 V pin is up or the sink leaves
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         brk_wait <= '0;
      end else if (src_pins_o.rail_20v_select || !cc_seen) begin
         brk_wait <= '0;
      end else if (!src_pins_o.rail_9v_select &&
         (brk_wait != '0 || state == PDSEQ_SRC_BREAK)) begin
         brk_wait <= brk_wait + GAP_W'(1); // R9
      end else begin
         brk_wait <= '0;
      end
   end

   property p_sink_start;
      @(posedge clk_i) disable iff (!nrst_i)
      $rose(nrst_i) |-> !source_role_o;
   endproperty
   a_sink_start: assert property (p_sink_start) // R1
      else $error("port left reset not in sink role");

   property p_load_after_sink_current_select;
      @(posedge clk_i) disable iff (!nrst_i)
      $rose(sink_pins_o.load_switch_enable) |->
         $past(|sink_pins_o.sink_current_select);
   endproperty
   a_load_after_sink_current_select: assert property (p_load_after_sink_current_select) // R4
      else $error("load enable rose before current select");

   property p_sink_current_select_first;
      @(posedge clk_i) disable iff (!nrst_i)
      s_sink_current_select_up |-> !sink_pins_o.load_switch_enable;
   endproperty
   a_sink_current_select_first: assert property (p_sink_current_select_first) // R4
      else $error("load enable not low when current select rose");

   property p_load_gap;
      @(posedge clk_i) disable iff (!nrst_i)
      sink_current_select_wait < GAP_W'(PIN_GAP_CYC + 1);
   endproperty
   a_load_gap: assert property (p_load_gap) // R5
      else $error("load enable late after current select");

   property p_src_levels;
      @(posedge clk_i) disable iff (!nrst_i)
      (src_pins_o.rail_9v_select || src_pins_o.rail_20v_select) |->
         src_pins_o.source_supply_switch &&
         !(src_pins_o.rail_9v_select && src_pins_o.rail_20v_select);
   endproperty
   a_src_levels: assert property (p_src_levels) // R7
      else $error("rail pins inconsistent with supply switch");

   property p_start_5v;
      @(posedge clk_i) disable iff (!nrst_i)
      $rose(src_pins_o.source_supply_switch) |->
         !src_pins_o.rail_9v_select && !src_pins_o.rail_20v_select;
   endproperty
   a_start_5v: assert property (p_start_5v) // R6
      else $error("supply did not start at 5 V");

   property p_9_to_20;
      @(posedge clk_i) disable iff (!nrst_i)
      brk_wait < GAP_W'(PIN_GAP_CYC + 1);
   endproperty
   a_9_to_20: assert property (p_9_to_20) // R9
      else $error("20 V rail late after 9 V drop");

   property p_attach;
      @(posedge clk_i) disable iff (!nrst_i)
      state == PDSEQ_SRC_UNATT && cc_seen |-> ##2 src_pins_o.vbus_on &&
         src_pins_o.vconn_on || !cc_seen;
   endproperty
   a_attach: assert property (p_attach) // R10
      else $error("VBUS and VCONN not on after attach");

   property p_no_early_vbus;
      @(posedge clk_i) disable iff (!nrst_i)
      $rose(src_pins_o.vbus_on) |-> $past(cc_seen);
   endproperty
   a_no_early_vbus: assert property (p_no_early_vbus) // R10
      else $error("VBUS on without sink pull-down");

   property p_back_5v;
      @(posedge clk_i) disable iff (!nrst_i)
      ($fell(src_pins_o.rail_9v_select) || $fell(src_pins_o.rail_20v_select))
         && cc_seen && state == PDSEQ_SRC_ON |->
         src_pins_o.source_supply_switch;
   endproperty
   a_back_5v: assert property (p_back_5v) // R12
      else $error("supply switch dropped on return to 5 V");

endmodule : pdseq_top
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking testbench for the power-profile pin sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import pdseq_pkg::*;
;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic i_ok = 1'b0, e_ok = 1'b0, i_swap = 1'b0, e_swap = 1'b0;
   logic e_take = 1'b0, cc = 1'b0;
   logic [1:0] i_prof = 2'h0, e_prof = 2'h0;
   pdseq_level_e i_lvl = PDSEQ_V5, e_lvl = PDSEQ_V5;
   pdseq_sink_pins_s snk;
   pdseq_src_pins_s src;
   logic role, load_on, clash;
   logic [4:0] volts;
   int fail_count = 0;
   int checks_done = 0;

   always #5 clk = ~clk;

   pdseq_top i_dut (.clk_i(clk), .nrst_i(nrst), .int_sink_ok_i(i_ok),
      .int_sink_prof_i(i_prof), .int_swap_i(i_swap), .int_level_i(i_lvl),
      .ext_take_i(e_take), .ext_sink_ok_i(e_ok), .ext_sink_prof_i(e_prof),
      .ext_swap_i(e_swap), .ext_level_i(e_lvl), .cc_sink_seen_i(cc),
      .sink_pins_o(snk), .src_pins_o(src), .source_role_o(role));
   pdseq_supply_model i_sup (.clk_i(clk), .nrst_i(nrst), .src_i(src),
      .sink_i(snk), .volts_o(volts), .load_on_o(load_on), .clash_o(clash));

   ////////////////////////////////////////////////////////////////////////
   task automatic complete_run;
      if (fail_count == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   function automatic logic sig(input int k);
      case (k)
         0: return snk.load_switch_enable;
         1: return src.rail_9v_select;
         2: return src.rail_20v_select;
         3: return src.vbus_on;
         4: return role;
         default: return |snk.sink_current_select;
      endcase
   endfunction : sig

   // Bounded wait; running out counts as a mismatch and ends the run
   task automatic wait_sig(input int k, input logic v, input int lim,
                           output int n);
      n = 0;
      while (sig(k) !== v) begin
         @(negedge clk);
         n++;
         if (n > lim) begin
            chk("wait_limit", 8'h01, 8'h00);
            complete_run();
         end
      end
   endtask : wait_sig

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      @(negedge clk);
      chk("sink_pins", 8'h00, 8'(snk));
      chk("src_pins", 8'h00, 8'(src));
      chk("role", 8'h00, 8'(role));
   endtask : t_reset

   // Other controller offers a different profile to prove the takeover
   task automatic t_sink(input logic ext, input logic [1:0] p);
      int n;
      @(posedge clk);
      e_take <= ext;
      i_prof <= ext ? ~p : p;
      e_prof <= ext ? p : ~p;
      i_ok <= 1'b1;
      e_ok <= 1'b1;
      wait_sig(5, 1'b1, 4, n);
      chk("load_en_early", 8'h00, 8'(snk.load_switch_enable));
      chk("cur_sel", 8'(p), 8'(snk.sink_current_select));
      wait_sig(0, 1'b1, PIN_GAP_CYC, n);
      chk("gap_seen", 8'h01, 8'(n > 0));
      @(negedge clk);
      chk("load_on", 8'h01, 8'(load_on));
      @(posedge clk);
      i_ok <= 1'b0;
      e_ok <= 1'b0;
      repeat (4) @(negedge clk);
      chk("sink_clear", 8'h00, 8'(snk));
   endtask : t_sink

   task automatic t_swap;
      int n;
      @(posedge clk);
      e_take <= 1'b0;
      i_swap <= 1'b1;
      wait_sig(4, 1'b1, 4, n);
      @(posedge clk);
      i_swap <= 1'b0;
      i_ok <= 1'b1;
      repeat (4) @(negedge clk);
      chk("no_sink_in_src", 8'h00, 8'(snk));
      chk("role_held", 8'h01, 8'(role));
      @(posedge clk);
      i_ok <= 1'b0;
   endtask : t_swap

   task automatic t_source;
      int n;
      pdseq_level_e lv[5] = '{PDSEQ_V9, PDSEQ_V5, PDSEQ_V20, PDSEQ_V5,
                              PDSEQ_V9};
      logic [7:0] ex[5] = '{8'h1b, 8'h13, 8'h17, 8'h13, 8'h1b};
      logic [7:0] ev[5] = '{8'h09, 8'h05, 8'h14, 8'h05, 8'h09};
      @(posedge clk);
      cc <= 1'b1;
      wait_sig(3, 1'b1, 10, n);
      chk("src_attach", 8'h13, 8'(src));
      for (int i = 0; i < 5; i++) begin
         @(posedge clk);
         i_lvl <= lv[i];
         repeat (4) @(negedge clk);
         chk("src_level", ex[i], 8'(src));
         chk("volts", ev[i], 8'(volts));
      end
      @(posedge clk);
      i_lvl <= PDSEQ_V20;
      wait_sig(1, 1'b0, 4, n);
      chk("r20_after_drop", 8'h00, 8'(src.rail_20v_select));
      chk("supply_held", 8'h01, 8'(src.source_supply_switch));
      wait_sig(2, 1'b1, PIN_GAP_CYC, n);
      chk("rail_clash", 8'h00, 8'(clash));
      @(posedge clk);
      cc <= 1'b0;
      wait_sig(3, 1'b0, 10, n);
      repeat (2) @(negedge clk);
      chk("src_detach", 8'h00, 8'(src));
   endtask : t_source

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_sink(1'b0, 2'h3);
      t_sink(1'b1, 2'h2);
      t_swap();
      t_source();
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
